// file: tcp_pkg.sv
// constants and types for the timer capture and pwm block
package tcp_pkg;
  localparam logic [5:0] ADDR_CTRL_A  = 6'h2f;
  localparam logic [5:0] ADDR_CTRL_B  = 6'h2e;
  localparam logic [5:0] ADDR_CNT_HI  = 6'h2d;
  localparam logic [5:0] ADDR_CNT_LO  = 6'h2c;
  localparam logic [5:0] ADDR_CMP_HI  = 6'h2b;
  localparam logic [5:0] ADDR_CMP_LO  = 6'h2a;
  localparam logic [5:0] ADDR_CAP_HI  = 6'h27;
  localparam logic [5:0] ADDR_CAP_LO  = 6'h26;
  localparam logic [5:0] ADDR_FLAGS   = 6'h38;
  localparam logic [5:0] ADDR_ENABLES = 6'h39;
  localparam int BIT_OVF = 0;
  localparam int BIT_CMP = 1;
  localparam int BIT_CAP = 2;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] TOP_8    = 16'h00ff;
  localparam logic [15:0] TOP_9    = 16'h01ff;
  localparam logic [15:0] TOP_10   = 16'h03ff;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [9:0]  PRE_8    = 10'h007;
  localparam logic [9:0]  PRE_64   = 10'h03f;
  localparam logic [9:0]  PRE_256  = 10'h0ff;
  localparam logic [9:0]  PRE_1024 = 10'h3ff;
  localparam logic [3:0]  SAMPLES_HIGH = 4'hf;
  localparam logic [3:0]  SAMPLES_LOW  = 4'h0;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } tcp_dir_type;

  // resolution select codes: 00 off, 01 8 bit, 10 9 bit, 11 10 bit
  function automatic logic [15:0] pwm_top(input logic [1:0] res);
    unique case (res)
      2'b01:   pwm_top = TOP_8;
      2'b10:   pwm_top = TOP_9;
      2'b11:   pwm_top = TOP_10;
      default: pwm_top = CNT_MAX;
    endcase
  endfunction
endpackage

// file: tcp_capture_filter.sv
// capture pin synchroniser, noise filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module tcp_capture_filter
  import tcp_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic capture_input_pin_i,
  input  wire logic capture_noise_filter_i,
  input  wire logic capture_edge_select_i,
  output logic      capture_event_o
);
  logic       sync1_reg;
  logic       sync2_reg;
  logic [3:0] hist_reg;
  logic       level_reg;
  logic       level_next;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      hist_reg  <= SAMPLES_LOW;
    end else begin
      sync1_reg <= capture_input_pin_i;
      sync2_reg <= sync1_reg;
      hist_reg  <= {hist_reg[2:0], sync2_reg};
    end
  end

  // with the filter on, filtered level only moves after four equal samples; with it off it follows sync2_reg
  always_comb begin
    level_next = level_reg;
    if (!capture_noise_filter_i)
      level_next = sync2_reg;
    else if (hist_reg == SAMPLES_HIGH) // see RULE17
      level_next = 1'b1;
    else if (hist_reg == SAMPLES_LOW)
      level_next = 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg       <= 1'b0;
      capture_event_o <= 1'b0;
    end else begin
      level_reg       <= level_next;
      // edge select 0 falling, 1 rising
      capture_event_o <= (level_next != level_reg) &&
                         (level_next == capture_edge_select_i); // see RULE16
    end
  end

  a_filter_agree: assert property ( // see RULE17
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    capture_noise_filter_i && $stable(capture_noise_filter_i) &&
    $rose(capture_event_o)
    |-> $past(hist_reg) == {4{capture_edge_select_i}})
    else $error("capture without four agreeing samples");
endmodule
`default_nettype wire

// file: tcp_timer.sv
// timer with input capture and phase correct pwm
// What this block and its software do
// RULE1 - pin edge copies counter, sets capture flag
// RULE2 - capture register sixteen bits, writes ignored
// RULE3 - low byte read latches high byte
// RULE4 - software reads capture low byte first
// RULE5 - software masks interrupts around shared latch
// RULE6 - pwm counts up to top, down to zero
// RULE7 - top is 255, 511 or 1023
// RULE8 - pwm match uses low resolution bits only
// RULE9 - action codes: off, off, clear-up, set-up
// RULE10 - pwm compare writes held until top
// RULE11 - compare read returns held value
// RULE12 - compare zero or top gives fixed level
// RULE13 - overflow flag at turn at zero
// RULE14 - irq when flag, enable and global set
// RULE15 - resolution code selects pwm width or off
// RULE16 - edge select: zero falling, one rising
// RULE17 - filter needs four agreeing samples
// RULE18 - software writes compare high byte first
// RULE19 - flags clear on ack or written one
`timescale 1ns/1ps
`default_nettype none
module tcp_timer
  import tcp_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [5:0] io_addr_i,
  input  wire logic [7:0] io_wdata_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic       global_irq_en_i,
  input  wire logic       overflow_ack_i,
  input  wire logic       compare_ack_i,
  input  wire logic       capture_ack_i,
  input  wire logic       capture_input_pin_i,
  output logic [7:0]      io_rdata_o,
  output logic            compare_output_pin_o,
  output logic            compare_output_oe_n_o,
  output logic            overflow_irq_o,
  output logic            compare_irq_o,
  output logic            capture_irq_o
);
  logic [1:0]  output_action_reg;
  logic [1:0]  resolution_select_reg;
  logic        capture_noise_filter_reg;
  logic        capture_edge_select_reg;
  logic        clear_on_match_reg;
  logic [2:0]  clock_select_reg;
  logic [15:0] counter_value_reg;
  logic [15:0] counter_value_next;
  tcp_dir_type dir_reg;
  tcp_dir_type dir_next;
  logic [15:0] compare_hold_reg;
  logic [15:0] compare_active_reg;
  logic [15:0] capture_register_reg;
  logic [7:0]  temp_reg;
  logic [2:0]  flags_reg;
  logic [2:0]  enables_reg;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clr;
  logic [9:0]  pre_reg;
  logic        tick;
  logic        pwm_on;
  logic [15:0] top;
  logic        cnt_wr;
  logic        at_top_turn;
  logic        at_zero_turn;
  logic        match;
  logic        cap_event;

  assign pwm_on = (resolution_select_reg != 2'b00); // see RULE15
  assign top    = pwm_top(resolution_select_reg);   // see RULE7
  assign cnt_wr = io_wr_i && (io_addr_i == ADDR_CNT_LO);

  tcp_capture_filter tcp_capture_filter_i (
    .ref_clk_i              (ref_clk_i),
    .rst_n_i                (rst_n_i),
    .capture_input_pin_i    (capture_input_pin_i),
    .capture_noise_filter_i (capture_noise_filter_reg),
    .capture_edge_select_i  (capture_edge_select_reg),
    .capture_event_o        (cap_event)
  );

  // control registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_action_reg        <= 2'b00;
      resolution_select_reg    <= 2'b00;
      capture_noise_filter_reg <= 1'b0;
      capture_edge_select_reg  <= 1'b0;
      clear_on_match_reg       <= 1'b0;
      clock_select_reg         <= 3'h0;
      enables_reg              <= 3'h0;
    end else if (io_wr_i) begin
      if (io_addr_i == ADDR_CTRL_A) begin
        output_action_reg     <= io_wdata_i[7:6];
        resolution_select_reg <= io_wdata_i[1:0];
      end
      if (io_addr_i == ADDR_CTRL_B) begin
        capture_noise_filter_reg <= io_wdata_i[7];
        capture_edge_select_reg  <= io_wdata_i[6];
        clear_on_match_reg       <= io_wdata_i[3];
        clock_select_reg         <= io_wdata_i[2:0];
      end
      if (io_addr_i == ADDR_ENABLES)
        enables_reg <= io_wdata_i[2:0];
    end
  end

  // prescaler; external clock codes are not wired and stop the count
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      pre_reg <= 10'h000;
    else
      pre_reg <= pre_reg + 10'h001;
  end

  always_comb begin
    unique case (clock_select_reg)
      3'h1:    tick = 1'b1;
      3'h2:    tick = (pre_reg[2:0] == PRE_8[2:0]);
      3'h3:    tick = (pre_reg[5:0] == PRE_64[5:0]);
      3'h4:    tick = (pre_reg[7:0] == PRE_256[7:0]);
      3'h5:    tick = (pre_reg == PRE_1024);
      default: tick = 1'b0;
    endcase
  end

  // counter next value and turning points
  always_comb begin
    counter_value_next = counter_value_reg;
    dir_next           = dir_reg;
    at_top_turn  = pwm_on && tick && (dir_reg == DIR_UP) &&
                   (counter_value_reg >= top);
    at_zero_turn = pwm_on && tick && (dir_reg == DIR_DOWN) &&
                   (counter_value_reg == RST_WORD);
    if (tick) begin
      if (!pwm_on) begin
        dir_next = DIR_UP;
        if (clear_on_match_reg &&
            counter_value_reg == compare_active_reg)
          counter_value_next = RST_WORD;
        else
          counter_value_next = counter_value_reg + 16'h0001;
      end else if (at_top_turn) begin // see RULE6
        dir_next           = DIR_DOWN;
        counter_value_next = counter_value_reg - 16'h0001;
      end else if (at_zero_turn) begin
        dir_next           = DIR_UP;
        counter_value_next = counter_value_reg + 16'h0001;
      end else if (dir_reg == DIR_UP) begin
        counter_value_next = counter_value_reg + 16'h0001;
      end else begin
        counter_value_next = counter_value_reg - 16'h0001;
      end
    end
  end

  // a counter write beats a tick in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      counter_value_reg <= RST_WORD;
      dir_reg           <= DIR_UP;
    end else if (cnt_wr) begin
      counter_value_reg <= {temp_reg, io_wdata_i};
    end else begin
      counter_value_reg <= counter_value_next;
      dir_reg           <= dir_next;
    end
  end

  // compare holding and active values
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      compare_hold_reg   <= RST_WORD;
      compare_active_reg <= RST_WORD;
    end else begin
      if (io_wr_i && io_addr_i == ADDR_CMP_LO)
        compare_hold_reg <= {temp_reg, io_wdata_i}; // see RULE10
      // in pwm mode transfer only at top so a period never gets odd length; with pwm off copy every cycle
      if (!pwm_on || at_top_turn)
        compare_active_reg <= compare_hold_reg; // see RULE10
    end
  end

  assign match = tick &&
    (counter_value_next == (compare_active_reg & top)); // see RULE8

  // capture register has no write path at all
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      capture_register_reg <= RST_WORD;
    else if (cap_event)
      capture_register_reg <= counter_value_reg; // see RULE1 RULE2
  end

  // shared byte latch for 16 bit accesses
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      temp_reg <= RST_BYTE;
    else if (io_wr_i &&
             (io_addr_i == ADDR_CNT_HI || io_addr_i == ADDR_CMP_HI))
      temp_reg <= io_wdata_i;
    else if (io_rd_i && io_addr_i == ADDR_CNT_LO)
      temp_reg <= counter_value_reg[15:8];
    else if (io_rd_i && io_addr_i == ADDR_CAP_LO)
      temp_reg <= capture_register_reg[15:8]; // see RULE3
  end

  // read data is registered: valid the cycle after io_rd_i
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      io_rdata_o <= RST_BYTE;
    else if (io_rd_i) begin
      unique case (io_addr_i)
        ADDR_CTRL_A: io_rdata_o <= {output_action_reg, 4'h0,
                                    resolution_select_reg};
        ADDR_CTRL_B: io_rdata_o <= {capture_noise_filter_reg,
                                    capture_edge_select_reg, 2'b00,
                                    clear_on_match_reg, clock_select_reg};
        ADDR_CNT_LO: io_rdata_o <= counter_value_reg[7:0];
        ADDR_CNT_HI: io_rdata_o <= temp_reg;
        ADDR_CMP_LO: io_rdata_o <= compare_hold_reg[7:0]; // see RULE11
        ADDR_CMP_HI: io_rdata_o <= compare_hold_reg[15:8];
        ADDR_CAP_LO: io_rdata_o <= capture_register_reg[7:0];
        ADDR_CAP_HI: io_rdata_o <= temp_reg; // see RULE3
        ADDR_FLAGS:  io_rdata_o <= {5'h00, flags_reg};
        ADDR_ENABLES: io_rdata_o <= {5'h00, enables_reg};
        default:     io_rdata_o <= RST_BYTE;
      endcase
    end
  end

  // flags: a set in the same cycle as a clear wins
  always_comb begin
    flag_set = 3'h0;
    flag_set[BIT_OVF] = at_zero_turn ||
      (!pwm_on && tick && counter_value_next == RST_WORD &&
       counter_value_reg == CNT_MAX); // see RULE13
    flag_set[BIT_CMP] = match;
    flag_set[BIT_CAP] = cap_event; // see RULE1
    flag_clr = {capture_ack_i, compare_ack_i, overflow_ack_i};
    if (io_wr_i && io_addr_i == ADDR_FLAGS)
      flag_clr = flag_clr | io_wdata_i[2:0]; // see RULE19
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      flags_reg <= 3'h0;
    else
      flags_reg <= flag_set | (flags_reg & ~flag_clr);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_irq_o <= 1'b0;
      compare_irq_o  <= 1'b0;
      capture_irq_o  <= 1'b0;
    end else begin
      overflow_irq_o <= flags_reg[BIT_OVF] && enables_reg[BIT_OVF] &&
                        global_irq_en_i; // see RULE14
      compare_irq_o  <= flags_reg[BIT_CMP] && enables_reg[BIT_CMP] &&
                        global_irq_en_i;
      capture_irq_o  <= flags_reg[BIT_CAP] && enables_reg[BIT_CAP] &&
                        global_irq_en_i;
    end
  end

  // compare output pin
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      compare_output_pin_o  <= 1'b0;
      compare_output_oe_n_o <= 1'b1;
    end else begin
      compare_output_oe_n_o <= pwm_on ? !output_action_reg[1]
                                      : (output_action_reg == 2'b00);
      if (match && pwm_on && output_action_reg[1]) begin // see RULE9
        if ((compare_active_reg & top) == RST_WORD) // see RULE12
          compare_output_pin_o <= output_action_reg[0];
        else if ((compare_active_reg & top) == top)
          compare_output_pin_o <= !output_action_reg[0];
        else
          compare_output_pin_o <= output_action_reg[0] ^
                                  (dir_next == DIR_DOWN);
      end else if (match && !pwm_on) begin
        unique case (output_action_reg)
          2'b01:   compare_output_pin_o <= !compare_output_pin_o;
          2'b10:   compare_output_pin_o <= 1'b0;
          2'b11:   compare_output_pin_o <= 1'b1;
          default: compare_output_pin_o <= compare_output_pin_o;
        endcase
      end
    end
  end

  sequence s_cap_lo_read;
    io_rd_i && io_addr_i == ADDR_CAP_LO;
  endsequence
  sequence s_cap_hi_read;
    io_rd_i && io_addr_i == ADDR_CAP_HI && !io_wr_i;
  endsequence
  sequence s_bus_idle;
    !io_rd_i && !io_wr_i;
  endsequence
  sequence s_cmp_lo_write;
    io_wr_i && io_addr_i == ADDR_CMP_LO;
  endsequence
  sequence s_cmp_lo_read;
    io_rd_i && io_addr_i == ADDR_CMP_LO && !io_wr_i;
  endsequence

  a_capture_copy: assert property ( // see RULE1
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cap_event |=> capture_register_reg == $past(counter_value_reg) &&
                  flags_reg[BIT_CAP])
    else $error("capture did not copy counter or set flag");
  a_capture_ro: assert property ( // see RULE2
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    io_wr_i && !cap_event &&
    (io_addr_i == ADDR_CAP_LO || io_addr_i == ADDR_CAP_HI)
    |=> $stable(capture_register_reg))
    else $error("capture register changed on write");
  a_capture_pair: assert property ( // see RULE3
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_cap_lo_read ##1 s_bus_idle ##1 s_cap_hi_read
    |=> io_rdata_o == $past(capture_register_reg[15:8], 3))
    else $error("high byte read not from latched value");
  a_pwm_top_turn: assert property ( // see RULE6 RULE7
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    at_top_turn && !cnt_wr && counter_value_reg == top
    |=> dir_reg == DIR_DOWN && counter_value_reg == $past(top) - 16'h0001)
    else $error("pwm counter did not turn at top");
  a_zero_turn: assert property ( // see RULE13
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    at_zero_turn && !cnt_wr
    |=> flags_reg[BIT_OVF] && dir_reg == DIR_UP &&
        counter_value_reg == 16'h0001)
    else $error("turn at zero missed overflow");
  a_hold_until_top: assert property ( // see RULE10
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    pwm_on && !at_top_turn |=> $stable(compare_active_reg))
    else $error("active compare changed away from top");
  a_compare_readback: assert property ( // see RULE11
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_cmp_lo_write ##1 s_bus_idle ##1 s_cmp_lo_read
    |=> io_rdata_o == $past(io_wdata_i, 3))
    else $error("compare read did not return last write");
  a_noninv_up: assert property ( // see RULE9
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    match && pwm_on && output_action_reg == 2'b10 &&
    dir_next == DIR_UP && (compare_active_reg & top) != RST_WORD &&
    (compare_active_reg & top) != top
    |=> !compare_output_pin_o)
    else $error("up count match did not clear output");
  a_irq_request: assert property ( // see RULE14
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    flags_reg[BIT_OVF] && enables_reg[BIT_OVF] && global_irq_en_i
    |=> overflow_irq_o)
    else $error("overflow irq not requested");
  a_flag_ack: assert property ( // see RULE19
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    capture_ack_i && !cap_event |=> !flags_reg[BIT_CAP])
    else $error("capture flag not cleared by ack");
endmodule
`default_nettype wire

// file: test_timer1_capture_and_phase_correct_pwm.sv
// self-checking testbench for the timer capture and pwm block
`timescale 1ns/1ps
`default_nettype none
module test_timer1_capture_and_phase_correct_pwm;
  import tcp_pkg::*;
  logic       ref_clk_i;
  logic       rst_n_i;
  logic [5:0] io_addr_i;
  logic [7:0] io_wdata_i;
  logic       io_wr_i;
  logic       io_rd_i;
  logic       global_irq_en_i;
  logic       overflow_ack_i;
  logic       compare_ack_i;
  logic       capture_ack_i;
  logic       capture_input_pin_i;
  logic [7:0] io_rdata_o;
  logic       compare_output_pin_o;
  logic       compare_output_oe_n_o;
  logic       overflow_irq_o;
  logic       compare_irq_o;
  logic       capture_irq_o;
  int         err_count;
  int         tests_run;

  tcp_timer tcp_timer_i (
    .ref_clk_i             (ref_clk_i),
    .rst_n_i               (rst_n_i),
    .io_addr_i             (io_addr_i),
    .io_wdata_i            (io_wdata_i),
    .io_wr_i               (io_wr_i),
    .io_rd_i               (io_rd_i),
    .global_irq_en_i       (global_irq_en_i),
    .overflow_ack_i        (overflow_ack_i),
    .compare_ack_i         (compare_ack_i),
    .capture_ack_i         (capture_ack_i),
    .capture_input_pin_i   (capture_input_pin_i),
    .io_rdata_o            (io_rdata_o),
    .compare_output_pin_o  (compare_output_pin_o),
    .compare_output_oe_n_o (compare_output_oe_n_o),
    .overflow_irq_o        (overflow_irq_o),
    .compare_irq_o         (compare_irq_o),
    .capture_irq_o         (capture_irq_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // strobes are one cycle wide; a read has side effects on the shared latch
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    io_addr_i  = a;
    io_wdata_i = d;
    io_wr_i    = 1'b1;
    @(negedge ref_clk_i);
    io_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    io_addr_i = a;
    io_rd_i   = 1'b1;
    @(negedge ref_clk_i);
    io_rd_i = 1'b0;
    d       = io_rdata_o;
  endtask

  task automatic chk_rd(input string n, input logic [5:0] a,
                        input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask

  task automatic wait_pin(input logic v, output int n);
    n = 0;
    while (compare_output_pin_o !== v) begin
      @(negedge ref_clk_i);
      n++;
      if (n > 3000) begin
        chk("pin wait", 16'h0000, 16'hffff);
        test_done();
      end
    end
  endtask

  task automatic sc_regs();
    chk("oe_n at reset", 16'h0001, compare_output_oe_n_o);
    chk_rd("capture lo reset", ADDR_CAP_LO, 8'h00);
    wr(ADDR_CTRL_A, 8'hff);
    chk_rd("ctrl a reserved", ADDR_CTRL_A, 8'hc3);
    wr(ADDR_CTRL_A, 8'h00);
  endtask

  task automatic sc_capture();
    wr(ADDR_ENABLES, 8'h04);
    global_irq_en_i = 1'b1;
    wr(ADDR_CNT_HI, 8'h12);
    wr(ADDR_CNT_LO, 8'h34);
    wr(ADDR_CTRL_B, 8'h40);
    capture_input_pin_i = 1'b1;
    wt(10);
    chk_rd("capture flag", ADDR_FLAGS, 8'h04);
    chk("capture irq", 16'h0001, capture_irq_o);
    chk_rd("capture lo", ADDR_CAP_LO, 8'h34);
    wr(ADDR_CAP_LO, 8'hff);
    wr(ADDR_CAP_HI, 8'hff);
    chk_rd("capture hi", ADDR_CAP_HI, 8'h12);
    chk_rd("capture lo kept", ADDR_CAP_LO, 8'h34);
    capture_ack_i = 1'b1;
    wt(1);
    capture_ack_i = 1'b0;
    wt(3);
    chk("capture irq ack", 16'h0000, capture_irq_o);
    wr(ADDR_CNT_HI, 8'h0a);
    wr(ADDR_CNT_LO, 8'hbc);
    capture_input_pin_i = 1'b0;
    wt(10);
    chk_rd("falling ignored", ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL_B, 8'h00);
    capture_input_pin_i = 1'b1;
    wt(10);
    chk_rd("rising ignored", ADDR_FLAGS, 8'h00);
    capture_input_pin_i = 1'b0;
    wt(10);
    chk_rd("falling taken", ADDR_FLAGS, 8'h04);
    chk_rd("capture lo 2", ADDR_CAP_LO, 8'hbc);
    chk_rd("capture hi 2", ADDR_CAP_HI, 8'h0a);
    wr(ADDR_FLAGS, 8'h04);
    chk_rd("flag write one", ADDR_FLAGS, 8'h00);
  endtask

  // pulses one sample short of the filter length must not capture
  task automatic sc_filter();
    wr(ADDR_CTRL_B, 8'hc0);
    capture_input_pin_i = 1'b1;
    wt(3);
    capture_input_pin_i = 1'b0;
    wt(12);
    chk_rd("short pulse", ADDR_FLAGS, 8'h00);
    capture_input_pin_i = 1'b1;
    wt(12);
    chk_rd("long pulse", ADDR_FLAGS, 8'h04);
    capture_input_pin_i = 1'b0;
    wr(ADDR_FLAGS, 8'h07);
  endtask

  // waits long enough for any held compare value to reach the active one
  task automatic pwm_setup(input logic [1:0] res, input logic [1:0] act,
                           input logic [15:0] cmp);
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_CTRL_A, {act, 4'h0, res});
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CMP_HI, cmp[15:8]);
    wr(ADDR_CMP_LO, cmp[7:0]);
    wr(ADDR_CTRL_B, 8'h01);
    wt(2100);
  endtask

  task automatic sc_pwm_period();
    int          n;
    int          m;
    logic [15:0] top;
    for (int r = 1; r <= 3; r++) begin
      top = (r == 1) ? TOP_8 : (r == 2) ? TOP_9 : TOP_10;
      pwm_setup(2'(r), 2'b10, 16'hfc40);
      // phase after setup is arbitrary: start from a whole low level
      wait_pin(1'b0, n);
      wait_pin(1'b1, n);
      wait_pin(1'b0, n);
      chk("high time", 16'h0080, 16'(n));
      wait_pin(1'b1, m);
      chk("period", 16'(2 * top), 16'(n + m));
      chk("oe_n driven", 16'h0000, compare_output_oe_n_o);
    end
    pwm_setup(2'b01, 2'b11, 16'h0040);
    wait_pin(1'b1, n);
    wait_pin(1'b0, n);
    wait_pin(1'b1, n);
    chk("inverted low time", 16'h0080, 16'(n));
    wr(ADDR_CMP_HI, 8'h01);
    wr(ADDR_CMP_LO, 8'h23);
    chk_rd("held cmp lo", ADDR_CMP_LO, 8'h23);
    chk_rd("held cmp hi", ADDR_CMP_HI, 8'h01);
  endtask

  task automatic sc_fixed();
    logic [1:0]  acts[4] = '{2'b10, 2'b10, 2'b11, 2'b11};
    logic [15:0] cmps[4] = '{16'h0000, 16'h00ff, 16'h0000, 16'h00ff};
    logic        lvl[4]  = '{1'b0, 1'b1, 1'b1, 1'b0};
    int          bad;
    for (int k = 0; k < 4; k++) begin
      pwm_setup(2'b01, acts[k], cmps[k]);
      bad = 0;
      for (int i = 0; i < 520; i++) begin
        @(negedge ref_clk_i);
        if (compare_output_pin_o !== lvl[k]) bad++;
      end
      chk("fixed level", 16'h0000, 16'(bad));
    end
    for (int k = 0; k < 2; k++) begin
      pwm_setup(2'b01, 2'(k), 16'h0040);
      chk("oe_n off", 16'h0001, compare_output_oe_n_o);
    end
  endtask

  // normal mode: clear on match at /8 toggles the pin every four ticks
  task automatic sc_normal();
    int n;
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_CTRL_A, 8'h40);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CMP_HI, 8'h00);
    wr(ADDR_CMP_LO, 8'h03);
    wr(ADDR_CTRL_B, 8'h0a);
    wait_pin(1'b0, n);
    wait_pin(1'b1, n);
    wait_pin(1'b0, n);
    chk("toggle half period", 16'h0020, 16'(n));
    chk("oe_n normal", 16'h0000, compare_output_oe_n_o);
  endtask

  function automatic logic irq_of(input int b);
    return (b == 0) ? overflow_irq_o : compare_irq_o;
  endfunction

  task automatic irq_cycle(input int b);
    int         n;
    logic [7:0] lo;
    logic [7:0] hi;
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_ENABLES, 8'(1 << b));
    n = 0;
    while (irq_of(b) !== 1'b1 && n < 600) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("irq raised", 16'h0001, irq_of(b));
    if (n >= 600) test_done();
    global_irq_en_i = 1'b0;
    rd(ADDR_CNT_LO, lo);
    rd(ADDR_CNT_HI, hi);
    if (b == 0)
      chk("turn at zero", 16'h0001, {hi, lo} < 16'h0008);
    wt(2);
    chk("irq masked", 16'h0000, irq_of(b));
    global_irq_en_i = 1'b1;
    wt(2);
    overflow_ack_i = (b == 0);
    compare_ack_i  = (b == 1);
    wt(1);
    overflow_ack_i = 1'b0;
    compare_ack_i  = 1'b0;
    wt(3);
    chk("irq cleared", 16'h0000, irq_of(b));
  endtask

  initial begin
    err_count           = 0;
    tests_run           = 0;
    rst_n_i             = 1'b0;
    io_addr_i           = 6'h00;
    io_wdata_i          = 8'h00;
    io_wr_i             = 1'b0;
    io_rd_i             = 1'b0;
    global_irq_en_i     = 1'b0;
    overflow_ack_i      = 1'b0;
    compare_ack_i       = 1'b0;
    capture_ack_i       = 1'b0;
    capture_input_pin_i = 1'b0;
    wt(10);
    rst_n_i = 1'b1;
    sc_regs();
    sc_capture();
    sc_filter();
    sc_pwm_period();
    sc_fixed();
    sc_normal();
    pwm_setup(2'b01, 2'b10, 16'h0040);
    irq_cycle(0);
    irq_cycle(1);
    test_done();
  end
endmodule
`default_nettype wire
